// file: shared/chgsw_cfg.svh
// Offsets, field positions, reset values and timing counts of the charger switch control
//
// Operation
// R01: The input current limit is the sum of bits 7..12 of the setting, weighted 256mA to 8192mA.
// R02: Bits 0..6 and 13..15 of the input-limit setting never contribute to the limit.
// R03: Thermistor above 0.91 of supply sets overrange and blocks wake-up and controlled charge.
// R04: Thermistor above 0.75 sets cold; controlled charge stays allowed, wake-up until timeout.
// R05: Between 0.23 and 0.75 no flag is set; controlled allowed, wake-up until timeout.
// R06: Thermistor below 0.23 sets hot, which blocks both kinds of charging.
// R07: Thermistor below 0.05 sets underrange, which allows both kinds of charging over hot.
// R08: After an off-period a cycle starts only with cycle permit high and peak limit low.
// R09: A peak-limit trip ends the high-side on-period at once.
// R10: Zero current during the off-period turns the low side off; both stay off until restart.
// R11: With battery at or above 0.88 of input the off-period is fixed and never below minimum; the code applies no minimum floor in dropout.
// R12: Otherwise the off-period is 2.5us times (input minus battery) over input.
// R13: In discontinuous conduction no cycle starts until the control point is above 100mV.
// R14: Discontinuous conduction is entered whenever the control point falls below 100mV; the code tests this only when an off-period ends and no cycle can start.
// R15: A cycle starts high side on, low side off, and on-time ends on the on-time compare.
// R16: After the high side turns off a fixed dead time passes before the low side turns on.
// R17: Comparators are synchronised, and a down-counter loaded at on-time end times the off-period.
`ifndef CHGSW_CFG_SVH
`define CHGSW_CFG_SVH

// ****************************************************************
// Command port
// ****************************************************************
`define CHGSW_CMD_INPUT_LIMIT   8'h3F
`define CHGSW_LIMIT_LSB         7
`define CHGSW_LIMIT_MSB         12
`define CHGSW_LIMIT_RESET       6'h00
`define CHGSW_LIMIT_UNIT_SHIFT  8

// ****************************************************************
// Thermistor thresholds, percent of supply, and full-scale code
// ****************************************************************
`define CHGSW_THM_OR_PCT        7'h5B
`define CHGSW_THM_COLD_PCT      7'h4B
`define CHGSW_THM_HOT_PCT       7'h17
`define CHGSW_THM_UR_PCT        7'h05
`define CHGSW_CODE_FULL         10'h3FF

// ****************************************************************
// Timing, in ns at the core clock, and derived cycle counts
// ****************************************************************
`define CHGSW_CLK_NS            16'h0064
`define CHGSW_TOFF_NOM_NS       16'h09C4
`define CHGSW_TOFF_MIN_NS       16'h012C
`define CHGSW_TOFF_FIX_NS       16'h010E
`define CHGSW_DEAD_NS           16'h0032
`define CHGSW_TOFF_NOM_CYC      (`CHGSW_TOFF_NOM_NS / `CHGSW_CLK_NS)
`define CHGSW_TOFF_MIN_CYC      ((`CHGSW_TOFF_MIN_NS + `CHGSW_CLK_NS - 16'h0001) / `CHGSW_CLK_NS)
`define CHGSW_TOFF_FIX_CYC      ((`CHGSW_TOFF_FIX_NS + `CHGSW_CLK_NS - 16'h0001) / `CHGSW_CLK_NS)
`define CHGSW_DEAD_CYC          ((`CHGSW_DEAD_NS + `CHGSW_CLK_NS - 16'h0001) / `CHGSW_CLK_NS)
`define CHGSW_DROPOUT_PCT       7'h58

`endif

// file: shared/chgsw_pkg.sv
// Types shared by the charger switch control modules
package chgsw_pkg;

  // Switching states, Gray coded along idle-on-dead-off-dcm
  typedef enum logic [2:0] {
    CHGSW_IDLE = 3'h0,
    CHGSW_ON   = 3'h1,
    CHGSW_DEAD = 3'h3,
    CHGSW_OFF  = 3'h2,
    CHGSW_DCM  = 3'h6
  } chgsw_state_e;

  typedef logic [9:0] chgsw_code_t;
  typedef logic [4:0] chgsw_cnt_t;

endpackage

// file: rtl/chgsw_offtime.sv
// Off-period sizing and down-counter for the switch control
`timescale 1ns/100ps
`include "chgsw_cfg.svh"
module chgsw_offtime
(
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  input  wire logic                 load_in,
  input  wire chgsw_pkg::chgsw_code_t supply_code_in,
  input  wire chgsw_pkg::chgsw_code_t battery_code_in,
  output logic                      done_out,
  output logic                      dropout_out
);
  import chgsw_pkg::*;

  // Nominal off cycles, floor of nominal * (vin - vbat) / vin by repeated addition
  function automatic chgsw_cnt_t chgsw_off_cycles(input chgsw_code_t vin, input chgsw_code_t vbat);
    logic [15:0] num;
    logic [15:0] acc;
    chgsw_cnt_t  n;
    num = 16'h0000;
    acc = 16'h0000;
    n   = 5'h00;
    if (vbat < vin)
      num = 16'(`CHGSW_TOFF_NOM_CYC) * 16'(vin - vbat);
    for (int k = 0; k < 25; k++)
    begin
      acc = acc + 16'(vin);
      if (acc <= num)
        n = n + 5'h01;
    end
    return n;
  endfunction

  chgsw_cnt_t cnt_reg;
  chgsw_cnt_t cnt_next;
  chgsw_cnt_t load_val;
  logic       drop_reg;
  logic       drop_next;

  // Dropout test and length selection
  always_comb
  begin
    drop_next = (20'(battery_code_in) * 20'h00064) >=
                (20'(supply_code_in) * 20'(`CHGSW_DROPOUT_PCT));
    // R11: fixed short off-time
    if (drop_next)
      load_val = 5'(`CHGSW_TOFF_FIX_CYC);
    else
      // R12: scaled nominal off-time
      load_val = chgsw_off_cycles(supply_code_in, battery_code_in);
    // R12 path: floor at minimum, applied only outside dropout
    if (load_val < 5'(`CHGSW_TOFF_MIN_CYC) && !drop_next)
      load_val = 5'(`CHGSW_TOFF_MIN_CYC);
    cnt_next = cnt_reg;
    // R17: load at on-time end, then count down
    if (load_in)
      cnt_next = load_val;
    else if (cnt_reg != 5'h00)
      cnt_next = cnt_reg - 5'h01;
  end

  // Counter registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cnt_reg  <= 5'h00;
      drop_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      drop_reg <= drop_next;
    end
  end

  assign done_out    = (cnt_reg == 5'h00);
  assign dropout_out = drop_reg;

endmodule // chgsw_offtime

// file: rtl/chgsw_top.sv
// Cycle control, input-limit decode and thermistor status for the charger power stage
`timescale 1ns/100ps
`include "chgsw_cfg.svh"
module chgsw_top
#(
  parameter int unsigned TICK_CYC        = 10000,
  parameter int unsigned WAKE_TIMEOUT_MS = 1000
)
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire logic                   cycle_permit_comparator_in,
  input  wire logic                   peak_limit_comparator_in,
  input  wire logic                   zero_current_comparator_in,
  input  wire logic                   on_time_end_comparator_in,
  input  wire chgsw_pkg::chgsw_code_t supply_input_pin_code_in,
  input  wire chgsw_pkg::chgsw_code_t battery_sense_pin_code_in,
  input  wire chgsw_pkg::chgsw_code_t therm_code_in,
  input  wire logic                   switch_enable_in,
  input  wire logic                   wake_charge_req_in,
  input  wire logic                   cmd_write_in,
  input  wire logic [7:0]             cmd_code_in,
  input  wire logic [15:0]            cmd_data_in,
  output logic                        high_side_drive_out,
  output logic                        low_side_drive_out,
  output logic                        discontinuous_out,
  output logic                        dropout_out,
  output logic [5:0]                  input_limit_dac_bits_out,
  output logic [13:0]                 input_limit_ma_out,
  output logic                        therm_overrange_out,
  output logic                        therm_cold_out,
  output logic                        therm_hot_out,
  output logic                        therm_underrange_flag_out,
  output logic                        wake_charge_ok_out,
  output logic                        ctrl_charge_ok_out
);
  import chgsw_pkg::*;

  // Thermistor code above a percentage of the full-scale supply code
  function automatic logic chgsw_above(input chgsw_code_t code, input logic [6:0] pct);
    return (20'(code) * 20'h00064) > (20'(pct) * 20'(`CHGSW_CODE_FULL));
  endfunction

  // Limit in mA from the six weighted bits
  function automatic logic [13:0] chgsw_limit_ma(input logic [5:0] dac);
    return {dac, 8'h00};
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  logic [3:0]  cmp_meta_reg;
  logic [3:0]  cmp_sync_reg;
  logic [3:0]  cmp_meta_next;
  logic [3:0]  cmp_sync_next;
  logic [29:0] code_meta_reg;
  logic [29:0] code_sync_reg;
  logic [29:0] code_meta_next;
  logic [29:0] code_sync_next;
  logic        permit;
  logic        peak;
  logic        zero_cur;
  logic        on_end;
  chgsw_code_t vin_code;
  chgsw_code_t vbat_code;
  chgsw_code_t thm_code;

  // R17: two flops on every comparator and code
  always_comb
  begin
    cmp_meta_next  = {cycle_permit_comparator_in, peak_limit_comparator_in,
                      zero_current_comparator_in, on_time_end_comparator_in};
    cmp_sync_next  = cmp_meta_reg;
    code_meta_next = {supply_input_pin_code_in, battery_sense_pin_code_in, therm_code_in};
    code_sync_next = code_meta_reg;
  end

  // Codes are slow analog samples; a torn word only lasts one cycle
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cmp_meta_reg  <= 4'h0;
      cmp_sync_reg  <= 4'h0;
      code_meta_reg <= 30'h00000000;
      code_sync_reg <= 30'h00000000;
    end
    else
    begin
      cmp_meta_reg  <= cmp_meta_next;
      cmp_sync_reg  <= cmp_sync_next;
      code_meta_reg <= code_meta_next;
      code_sync_reg <= code_sync_next;
    end
  end

  assign permit    = cmp_sync_reg[3];
  assign peak      = cmp_sync_reg[2];
  assign zero_cur  = cmp_sync_reg[1];
  assign on_end    = cmp_sync_reg[0];
  assign vin_code  = code_sync_reg[29:20];
  assign vbat_code = code_sync_reg[19:10];
  assign thm_code  = code_sync_reg[9:0];

  // ****************************************************************
  // Input current limit setting
  // ****************************************************************

  logic [5:0]  dac_reg;
  logic [5:0]  dac_next;
  logic [13:0] ma_reg;
  logic [13:0] ma_next;

  // Write on command code match
  always_comb
  begin
    dac_next = dac_reg;
    ma_next  = ma_reg;
    if (cmd_write_in && cmd_code_in == `CHGSW_CMD_INPUT_LIMIT)
    begin
      // R02: drop unused positions
      dac_next = cmd_data_in[`CHGSW_LIMIT_MSB:`CHGSW_LIMIT_LSB];
      // R01: sum of 256mA..8192mA weights
      ma_next  = chgsw_limit_ma(dac_next);
    end
  end

  // Setting registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      dac_reg <= `CHGSW_LIMIT_RESET;
      ma_reg  <= 14'h0000;
    end
    else
    begin
      dac_reg <= dac_next;
      ma_reg  <= ma_next;
    end
  end

  assign input_limit_dac_bits_out = dac_reg;
  assign input_limit_ma_out       = ma_reg;

  // ****************************************************************
  // Thermistor status and charge permits
  // ****************************************************************

  logic        or_reg;
  logic        cold_reg;
  logic        hot_reg;
  logic        ur_reg;
  logic        wake_ok_reg;
  logic        ctrl_ok_reg;
  logic        or_next;
  logic        cold_next;
  logic        hot_next;
  logic        ur_next;
  logic        wake_ok_next;
  logic        ctrl_ok_next;
  logic [13:0] tick_reg;
  logic [13:0] tick_next;
  logic [15:0] wake_ms_reg;
  logic [15:0] wake_ms_next;
  logic        tick_en;
  logic        wake_expired;

  // Millisecond enable and wake-up timeout count
  always_comb
  begin
    tick_en      = (tick_reg == 14'(TICK_CYC - 1));
    tick_next    = tick_en ? 14'h0000 : tick_reg + 14'h0001;
    wake_expired = (wake_ms_reg >= 16'(WAKE_TIMEOUT_MS));
    wake_ms_next = wake_ms_reg;
    if (!wake_charge_req_in)
      wake_ms_next = 16'h0000;
    else if (tick_en && !wake_expired)
      wake_ms_next = wake_ms_reg + 16'h0001;
  end

  // Flag and permit decode; several flags may stand together
  always_comb
  begin
    // R03: overrange above 0.91
    or_next   = chgsw_above(thm_code, `CHGSW_THM_OR_PCT);
    // R04: cold above 0.75
    cold_next = chgsw_above(thm_code, `CHGSW_THM_COLD_PCT);
    // R06: hot below 0.23
    hot_next  = !chgsw_above(thm_code, `CHGSW_THM_HOT_PCT) &&
                ((20'(thm_code) * 20'h00064) != (20'(`CHGSW_THM_HOT_PCT) * 20'h003FF));
    // R07: underrange below 0.05
    ur_next   = !chgsw_above(thm_code, `CHGSW_THM_UR_PCT) &&
                ((20'(thm_code) * 20'h00064) != (20'(`CHGSW_THM_UR_PCT) * 20'h003FF));
    if (or_next)
    begin
      // R03: block both
      wake_ok_next = 1'b0;
      ctrl_ok_next = 1'b0;
    end
    else if (ur_next)
    begin
      // R07: allow both over hot
      wake_ok_next = 1'b1;
      ctrl_ok_next = 1'b1;
    end
    else if (hot_next)
    begin
      // R06: block both
      wake_ok_next = 1'b0;
      ctrl_ok_next = 1'b0;
    end
    else
    begin
      // R04: cold keeps charge, wake timed
      // R05: normal range, wake timed
      wake_ok_next = !wake_expired;
      ctrl_ok_next = 1'b1;
    end
  end

  // Status registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      or_reg      <= 1'b0;
      cold_reg    <= 1'b0;
      hot_reg     <= 1'b0;
      ur_reg      <= 1'b0;
      wake_ok_reg <= 1'b0;
      ctrl_ok_reg <= 1'b0;
      tick_reg    <= 14'h0000;
      wake_ms_reg <= 16'h0000;
    end
    else
    begin
      or_reg      <= or_next;
      cold_reg    <= cold_next;
      hot_reg     <= hot_next;
      ur_reg      <= ur_next;
      wake_ok_reg <= wake_ok_next;
      ctrl_ok_reg <= ctrl_ok_next;
      tick_reg    <= tick_next;
      wake_ms_reg <= wake_ms_next;
    end
  end

  assign therm_overrange_out       = or_reg;
  assign therm_cold_out            = cold_reg;
  assign therm_hot_out             = hot_reg;
  assign therm_underrange_flag_out = ur_reg;
  assign wake_charge_ok_out        = wake_ok_reg;
  assign ctrl_charge_ok_out        = ctrl_ok_reg;

  // ****************************************************************
  // Switching cycle control
  // ****************************************************************

  chgsw_state_e st_reg;
  chgsw_state_e st_next;
  logic [2:0]   dead_reg;
  logic [2:0]   dead_next;
  logic         hs_reg;
  logic         hs_next;
  logic         ls_reg;
  logic         ls_next;
  logic         dcm_reg;
  logic         dcm_next;
  logic         off_load;
  logic         off_done;
  logic         drop_flag;
  logic         run;
  logic         start_ok;

  // Off-period timer
  chgsw_offtime u_offtime
  (
    .mclk_in         (mclk_in),
    .rst_in          (rst_in),
    .load_in         (off_load),
    .supply_code_in  (vin_code),
    .battery_code_in (vbat_code),
    .done_out        (off_done),
    .dropout_out     (drop_flag)
  );

  // Next state; drives follow the next state so they come from flops
  always_comb
  begin
    run       = switch_enable_in && ctrl_ok_reg;
    // R08: permit high and no overcurrent
    start_ok  = run && permit && !peak;
    st_next   = st_reg;
    dead_next = 3'h0;
    dcm_next  = dcm_reg;
    off_load  = 1'b0;
    unique case (st_reg)
      CHGSW_IDLE:
        if (start_ok)
          st_next = CHGSW_ON;
      CHGSW_ON:
        // R09: peak trip ends on-time
        // R15: on-time compare ends on-time
        if (peak || on_end)
        begin
          st_next  = CHGSW_DEAD;
          off_load = 1'b1;
        end
      CHGSW_DEAD:
        // R16: dead time before low side
        if (dead_reg >= 3'(`CHGSW_DEAD_CYC - 16'h0001))
          st_next = CHGSW_OFF;
        else
          dead_next = dead_reg + 3'h1;
      CHGSW_OFF:
        // R10: zero current, both off
        if (zero_cur)
        begin
          st_next  = CHGSW_DCM;
          dcm_next = 1'b1;
        end
        else if (off_done)
        begin
          if (start_ok)
          begin
            st_next  = CHGSW_ON;
            dcm_next = 1'b0;
          end
          // R14: low control point enters discontinuous
          else if (!permit)
          begin
            st_next  = CHGSW_DCM;
            dcm_next = 1'b1;
          end
        end
      CHGSW_DCM:
        // R13: wait for control point above 100mV
        if (start_ok && off_done)
        begin
          st_next  = CHGSW_ON;
          dcm_next = 1'b0;
        end
      default:
        st_next = CHGSW_IDLE;
    endcase
    // Disable drops to idle even mid-cycle; losing the off-time is safe
    if (!run)
    begin
      st_next  = CHGSW_IDLE;
      dcm_next = 1'b0;
    end
    // R15: high on, low off in on-state
    hs_next = (st_next == CHGSW_ON);
    ls_next = (st_next == CHGSW_OFF);
  end

  // Cycle registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_reg   <= CHGSW_IDLE;
      dead_reg <= 3'h0;
      hs_reg   <= 1'b0;
      ls_reg   <= 1'b0;
      dcm_reg  <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      dead_reg <= dead_next;
      hs_reg   <= hs_next;
      ls_reg   <= ls_next;
      dcm_reg  <= dcm_next;
    end
  end

  assign high_side_drive_out = hs_reg;
  assign low_side_drive_out  = ls_reg;
  assign discontinuous_out   = dcm_reg;
  assign dropout_out         = drop_flag;

endmodule // chgsw_top

// file: testbench/chgsw_stage_model.sv
// Power stage stand-in: turns drive levels into comparator levels
`timescale 1ns/100ps
module chgsw_stage_model
(
  input  wire logic       mclk_in,
  input  wire logic       high_side_drive_in,
  input  wire logic       low_side_drive_in,
  input  wire logic [3:0] on_len_in,
  input  wire logic [3:0] zero_len_in,
  output logic            on_time_end_comparator_out,
  output logic            zero_current_comparator_out
);
  logic [3:0] hi_cnt_reg = 4'h0;
  logic [3:0] lo_cnt_reg = 4'h0;

  // Conduction time stands in for the ramp
  always @(posedge mclk_in)
  begin
    hi_cnt_reg <= high_side_drive_in ? hi_cnt_reg + 4'h1 : 4'h0;
    lo_cnt_reg <= low_side_drive_in ? lo_cnt_reg + 4'h1 : 4'h0;
  end

  assign on_time_end_comparator_out = high_side_drive_in && (hi_cnt_reg >= on_len_in);
  // current reaches zero; length 0 never
  assign zero_current_comparator_out = (zero_len_in != 4'h0) && (lo_cnt_reg >= zero_len_in);
endmodule // chgsw_stage_model

// file: testbench/chgsw_props.sv
// Port assertions for the switch control
`timescale 1ns/100ps
module chgsw_props
(
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        cycle_permit_comparator_in,
  input wire logic        peak_limit_comparator_in,
  input wire logic        on_time_end_comparator_in,
  input wire logic        zero_current_comparator_in,
  input wire logic        cmd_write_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic [9:0]  therm_code_in,
  input wire logic        high_side_drive_out,
  input wire logic        low_side_drive_out,
  input wire logic        discontinuous_out,
  input wire logic [5:0]  input_limit_dac_bits_out,
  input wire logic [13:0] input_limit_ma_out,
  input wire logic        therm_overrange_out,
  input wire logic        therm_cold_out,
  input wire logic        therm_hot_out,
  input wire logic        therm_underrange_flag_out,
  input wire logic        ctrl_charge_ok_out
);
  logic [31:0] t100;
  logic [3:0]  flg_e;

  // Expected {overrange, cold, hot, underrange}
  assign t100  = 32'(therm_code_in) * 32'h64;
  assign flg_e = {t100 > 32'h16BA5, t100 > 32'h12BB5, t100 < 32'h5BE9, t100 < 32'h13FB};

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_no_overlap: assert property (!(high_side_drive_out && low_side_drive_out))
    else $error("both drives on");
  a_dead_gap: assert property ($rose(low_side_drive_out) |-> !$past(high_side_drive_out))
    else $error("low side on without a dead cycle");
  a_limit_load: assert property (cmd_write_in && cmd_code_in == 8'h3F
    |=> input_limit_dac_bits_out == $past(cmd_data_in[12:7]))
    else $error("limit bits not taken");
  a_limit_weight: assert property (input_limit_ma_out == {input_limit_dac_bits_out, 8'h00})
    else $error("limit weight wrong");
  a_limit_other: assert property (cmd_write_in && cmd_code_in != 8'h3F
    |=> $stable(input_limit_dac_bits_out))
    else $error("foreign code changed limit");
  a_peak_stop: assert property (peak_limit_comparator_in [*3] |=> !high_side_drive_out)
    else $error("overcurrent left high side on");
  a_on_end_stop: assert property (on_time_end_comparator_in [*3] ##0 high_side_drive_out
    |=> !high_side_drive_out)
    else $error("on-time end ignored");
  a_zero_low: assert property (zero_current_comparator_in [*3] ##0 low_side_drive_out
    |=> !low_side_drive_out)
    else $error("low side on at zero current");
  a_start_gate: assert property ($rose(high_side_drive_out)
    |-> $past(cycle_permit_comparator_in, 3) && !$past(peak_limit_comparator_in, 3))
    else $error("cycle started without permit");
  a_dcm_exit: assert property ($fell(discontinuous_out) && high_side_drive_out
    |-> $past(cycle_permit_comparator_in, 3))
    else $error("left discontinuous mode without permit");
  a_therm_flags: assert property ($stable(therm_code_in) [*4] |=> {therm_overrange_out,
    therm_cold_out, therm_hot_out, therm_underrange_flag_out} == $past(flg_e))
    else $error("thermistor flags wrong");
  a_ctrl_permit: assert property ($stable(therm_code_in) [*4]
    |=> ctrl_charge_ok_out == $past(!flg_e[3] && (flg_e[0] || !flg_e[1])))
    else $error("controlled charge permit wrong");

  c_cycle: cover property ($rose(high_side_drive_out));
  c_dcm: cover property ($rose(discontinuous_out));
  c_over: cover property (therm_overrange_out);
endmodule // chgsw_props

bind chgsw_top chgsw_props u_props (.*);

// file: testbench/tb_charger_switch_control.sv
// Self-checking bench for the charger switch control
`timescale 1ns/100ps
`include "chgsw_cfg.svh"
module tb_charger_switch_control;
  import chgsw_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_in, permit, peak, on_end, zero, sw_en, wake_req, cmd_wr;
  logic        hi, lo, dcm, drop, t_or, t_cold, t_hot, t_ur, wake_ok, ctrl_ok;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_data, d;
  logic [5:0]  dac, lim;
  logic [13:0] ma;
  logic [3:0]  on_len, zero_len;
  chgsw_code_t vin, vbat, therm;
  int          error_cnt, num_checks, seed, n, a, b;
  logic [15:0] ctab [4] = '{16'hFFFF, 16'hE07F, 16'h1F80, 16'h0080};
  logic [9:0]  ttab [10] = '{10'h000, 10'h033, 10'h034, 10'h0EB, 10'h0EC,
                             10'h2FF, 10'h300, 10'h3A2, 10'h3A3, 10'h3FF};
  logic [9:0]  xtab [3] = '{10'h300, 10'h200, 10'h010};

  always #50 mclk_in = ~mclk_in;

  chgsw_top #(.TICK_CYC(4), .WAKE_TIMEOUT_MS(3)) dut
  (
    .mclk_in                    (mclk_in),
    .rst_in                     (rst_in),
    .cycle_permit_comparator_in (permit),
    .peak_limit_comparator_in   (peak),
    .zero_current_comparator_in (zero),
    .on_time_end_comparator_in  (on_end),
    .supply_input_pin_code_in   (vin),
    .battery_sense_pin_code_in  (vbat),
    .therm_code_in              (therm),
    .switch_enable_in           (sw_en),
    .wake_charge_req_in         (wake_req),
    .cmd_write_in               (cmd_wr),
    .cmd_code_in                (cmd_code),
    .cmd_data_in                (cmd_data),
    .high_side_drive_out        (hi),
    .low_side_drive_out         (lo),
    .discontinuous_out          (dcm),
    .dropout_out                (drop),
    .input_limit_dac_bits_out   (dac),
    .input_limit_ma_out         (ma),
    .therm_overrange_out        (t_or),
    .therm_cold_out             (t_cold),
    .therm_hot_out              (t_hot),
    .therm_underrange_flag_out  (t_ur),
    .wake_charge_ok_out         (wake_ok),
    .ctrl_charge_ok_out         (ctrl_ok)
  );

  chgsw_stage_model u_stage
  (
    .mclk_in                     (mclk_in),
    .high_side_drive_in          (hi),
    .low_side_drive_in           (lo),
    .on_len_in                   (on_len),
    .zero_len_in                 (zero_len),
    .on_time_end_comparator_out  (on_end),
    .zero_current_comparator_out (zero)
  );

  // Compare and count; X never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Sample just after an edge
  task automatic settle(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  // Bounded wait for a high-side level
  task automatic wait_hi(input logic v);
    int k;
    k = 0;
    while (hi !== v && k < 300)
    begin
      settle(1);
      k++;
    end
    chk(hi, v);
  endtask

  // Edges from high-side fall to next rise
  task automatic off_len(output int cnt);
    wait_hi(1'b1);
    wait_hi(1'b0);
    cnt = 0;
    while (hi !== 1'b1 && cnt < 300)
    begin
      settle(1);
      cnt++;
      if (cnt == 1) chk(lo, 1'b1);
    end
    chk(lo, 1'b0);
  endtask

  // Off-period in edges, dropout or scaled
  function automatic int exp_off(input int vi, input int vb);
    int k;
    if (vb * 100 >= vi * 88) return 4;
    k = 25 * (vi - vb) / vi;
    return ((k < 3) ? 3 : k) + 1;
  endfunction

  // Expected {overrange, cold, hot, underrange, wake ok, controlled ok}
  function automatic logic [5:0] exp_thm(input int c, input bit lapsed);
    logic o, cd, h, u;
    o = c * 100 > 91 * 1023;
    cd = c * 100 > 75 * 1023;
    h = c * 100 < 23 * 1023;
    u = c * 100 < 5 * 1023;
    return {o, cd, h, u, !o && (u || (!h && !lapsed)), !o && (u || !h)};
  endfunction

  initial
  begin
    seed = 78561;
    {rst_in, permit, peak, sw_en, wake_req, cmd_wr} = 6'h20;
    cmd_code = 8'h00;
    cmd_data = 16'h0000;
    {vin, vbat, therm} = {10'h3FF, 10'h200, 10'h200};
    {on_len, zero_len} = 8'h40;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    settle(1);
    chk({dac, ma}, 20'h0);
    // Back-to-back writes: corners, random words, foreign codes
    lim = 6'h00;
    for (int i = 0; i < 25; i++)
    begin
      @(posedge mclk_in);
      d = (i < 4) ? ctab[i] : 16'($random(seed));
      cmd_wr <= (i < 24);
      cmd_code <= (i % 3 == 2) ? 8'($random(seed)) : `CHGSW_CMD_INPUT_LIMIT;
      cmd_data <= d;
      #1;
      if (i > 0) chk({dac, ma}, {lim, lim, 8'h00});
      if (cmd_wr && cmd_code == `CHGSW_CMD_INPUT_LIMIT) lim = d[12:7];
    end
    // Thermistor bands, fresh wake-up request
    foreach (ttab[i])
    begin
      @(posedge mclk_in);
      therm <= ttab[i];
      wake_req <= 1'b0;
      @(posedge mclk_in);
      wake_req <= 1'b1;
      settle(4);
      chk({t_or, t_cold, t_hot, t_ur, wake_ok, ctrl_ok}, exp_thm(ttab[i], 1'b0));
    end
    // Wake-up permit lapses except in underrange
    foreach (xtab[i])
    begin
      @(posedge mclk_in);
      therm <= xtab[i];
      settle(30);
      chk({t_or, t_cold, t_hot, t_ur, wake_ok, ctrl_ok}, exp_thm(xtab[i], 1'b1));
    end
    // Off-period, dropout boundary included
    @(posedge mclk_in);
    {therm, sw_en, permit} <= {10'h200, 2'h3};
    for (int i = 0; i < 12; i++)
    begin
      a = 200 + {$random(seed)} % 824;
      b = (i == 0) ? 0 : (i < 3) ? (a * 88 + 99) / 100 - i + 1 : {$random(seed)} % a;
      @(posedge mclk_in);
      vin <= 10'(a);
      vbat <= 10'(b);
      off_len(n);
      off_len(n);
      chk(n, exp_off(a, b));
      chk(drop, b * 100 >= a * 88);
    end
    // Overcurrent ends on-time, blocks restart
    @(posedge mclk_in);
    on_len <= 4'hF;
    wait_hi(1'b1);
    @(posedge mclk_in);
    peak <= 1'b1;
    settle(4);
    chk(hi, 1'b0);
    settle(40);
    chk(hi, 1'b0);
    @(posedge mclk_in);
    {peak, on_len} <= 5'h04;
    wait_hi(1'b1);
    // Low control point: discontinuous until it recovers
    @(posedge mclk_in);
    permit <= 1'b0;
    settle(60);
    chk({dcm, hi, lo}, 3'h4);
    @(posedge mclk_in);
    permit <= 1'b1;
    wait_hi(1'b1);
    chk(dcm, 1'b0);
    // Zero current drops the low side
    @(posedge mclk_in);
    {vbat, zero_len} <= 14'h0002;
    wait_hi(1'b1);
    wait_hi(1'b0);
    settle(7);
    chk({dcm, lo}, 2'h2);
    tally_and_finish();
  end

  // Watchdog well past a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_charger_switch_control
